/* hdl/rcf_top.v */
// Receive configuration register, frame filter and transfer start logic
//
// The APB register port was decided locally.
`timescale 1ns/100ps
`include "rcf_map.vh"
module rcf_top
#(
   parameter LEN_W = 16
)
(
   input  wire             CLK,
   input  wire             RST,
   input  wire             PSEL,
   input  wire             PENABLE,
   input  wire             PWRITE,
   input  wire [7:0]       PADDR,
   input  wire [31:0]      PWDATA,
   output wire [31:0]      PRDATA,
   output wire             PREADY,
   output wire             PSLVERR,
   input  wire             EEPROM_LARGE,
   input  wire             FRAME_END,
   input  wire [LEN_W-1:0] FRAME_LEN,
   input  wire             FRAME_BCAST,
   input  wire             FRAME_MCAST,
   input  wire             FRAME_PHYS,
   input  wire             FRAME_ERR,
   input  wire             EARLY_EVENT,
   input  wire [LEN_W-1:0] FIFO_PKT_BYTES,
   input  wire             FIFO_PKT_DONE,
   output wire             FCS_CHECK_EN,
   output reg              FRAME_ACCEPT,
   output reg              FRAME_DROP,
   output reg              DMA_START,
   output reg  [LEN_W-1:0] BURST_BYTES,
   output reg              BURST_UNLIMITED,
   output reg              EARLY_IRQ,
   output wire             IRQ
);

// Configuration and status storage
reg  [31:0]           rxcfg_reg;
reg  [31:0]           rxcfg_next;
reg  [`RCF_IRQ_W-1:0] istat_reg;
reg  [`RCF_IRQ_W-1:0] imask_reg;
reg  [31:0]           rdata_reg;
reg  [31:0]           rdata_next;
reg                   eetype_reg;
reg                   started_reg;
reg                   started_next;

// Combinational decode results
reg  [`RCF_IRQ_W-1:0] ev;
reg  [LEN_W-1:0]      fth_bytes;
reg                   fth_valid;
reg  [LEN_W-1:0]      burst_bytes_next;
reg                   burst_valid;
reg                   burst_free;

// Bus strobes and fields
wire                  acc_wr;
wire                  acc_rd;
wire                  wr_rxcfg;
wire                  wr_istat;
wire                  wr_imask;
wire                  hit;
wire [2:0]            fth;
wire [2:0]            burst;
wire                  err_ok;
wire                  runt_ok;
wire                  short_sel;
wire                  multi_sel;
wire [LEN_W-1:0]      chk_min;
wire                  addr_ok;
wire                  len_ok;
wire                  keep;
wire                  thr_hit;
wire                  start_now;
wire [31:0]           eetype_word;
wire [`RCF_IRQ_W-1:0] istat_next;

genvar                gi;

// APB strobes; zero wait state, unmapped address answers error
assign acc_wr   = PSEL & PENABLE & PWRITE;
assign acc_rd   = PSEL & ~PWRITE & ~PENABLE;
assign wr_rxcfg = acc_wr & (PADDR == `RCF_ADDR_RXCFG);
assign wr_istat = acc_wr & (PADDR == `RCF_ADDR_ISTAT);
assign wr_imask = acc_wr & (PADDR == `RCF_ADDR_IMASK);
assign hit      = (PADDR == `RCF_ADDR_RXCFG)
                | (PADDR == `RCF_ADDR_ISTAT)
                | (PADDR == `RCF_ADDR_IMASK);

// Bus answer signals
assign PREADY   = 1'b1;
assign PSLVERR  = PSEL & PENABLE & ~hit;
assign PRDATA   = rdata_reg;

// Field extraction
assign fth       = rxcfg_reg[`RCF_FTH_HI:`RCF_FTH_LO];
assign burst     = rxcfg_reg[`RCF_BURST_HI:`RCF_BURST_LO];
assign err_ok    = rxcfg_reg[`RCF_BIT_ERR];
assign runt_ok   = rxcfg_reg[`RCF_BIT_RUNT];
assign short_sel = rxcfg_reg[`RCF_BIT_SHORT];
assign multi_sel = rxcfg_reg[`RCF_BIT_MULTI];

// Minimum length for the frame check; error or runt overrides select
assign chk_min = (short_sel | err_ok | runt_ok)
               ? `RCF_LEN_SHORT
               : `RCF_LEN_MIN;

// Check enable; strictly larger than the minimum
assign FCS_CHECK_EN = (FRAME_LEN > chk_min);

// Threshold decode; reserved and whole-packet codes never hit
always @*
begin
   fth_bytes = {LEN_W{1'b0}};
   fth_valid = 1'b0;
   case (fth)
      `RCF_CODE_64:
      begin
         fth_bytes = `RCF_BYTES_64;
         fth_valid = 1'b1;
      end
      `RCF_CODE_128:
      begin
         fth_bytes = `RCF_BYTES_128;
         fth_valid = 1'b1;
      end
      `RCF_CODE_256:
      begin
         fth_bytes = `RCF_BYTES_256;
         fth_valid = 1'b1;
      end
      `RCF_CODE_512:
      begin
         fth_bytes = `RCF_BYTES_512;
         fth_valid = 1'b1;
      end
      `RCF_CODE_1024:
      begin
         fth_bytes = `RCF_BYTES_1024;
         fth_valid = 1'b1;
      end
      default:
      begin
         // Code 111 and reserved codes: whole packet only
         fth_bytes = {LEN_W{1'b0}};
         fth_valid = 1'b0;
      end
   endcase
end

// Burst limit decode; 111 lifts the cap, reserved codes give zero
always @*
begin
   burst_bytes_next = {LEN_W{1'b0}};
   burst_valid      = 1'b0;
   burst_free       = 1'b0;
   case (burst)
      `RCF_CODE_64:
      begin
         burst_bytes_next = `RCF_BYTES_64;
         burst_valid      = 1'b1;
      end
      `RCF_CODE_128:
      begin
         burst_bytes_next = `RCF_BYTES_128;
         burst_valid      = 1'b1;
      end
      `RCF_CODE_256:
      begin
         burst_bytes_next = `RCF_BYTES_256;
         burst_valid      = 1'b1;
      end
      `RCF_CODE_512:
      begin
         burst_bytes_next = `RCF_BYTES_512;
         burst_valid      = 1'b1;
      end
      `RCF_CODE_1024:
      begin
         burst_bytes_next = `RCF_BYTES_1024;
         burst_valid      = 1'b1;
      end
      `RCF_CODE_NONE:
      begin
         burst_bytes_next = {LEN_W{1'b0}};
         burst_valid      = 1'b1;
         burst_free       = 1'b1;
      end
      default:
      begin
         // Reserved codes: no cap value offered
         burst_bytes_next = {LEN_W{1'b0}};
         burst_valid      = 1'b0;
         burst_free       = 1'b0;
      end
   endcase
end

// Address category match
assign addr_ok = rxcfg_reg[`RCF_BIT_PROM]
               | (FRAME_BCAST & rxcfg_reg[`RCF_BIT_BCAST])
               | (FRAME_MCAST & rxcfg_reg[`RCF_BIT_MCAST])
               | (FRAME_PHYS  & rxcfg_reg[`RCF_BIT_PHYS]);

// Runt window and error gating after address match
assign len_ok = (FRAME_LEN >= `RCF_LEN_MIN)
              | (runt_ok & (FRAME_LEN >= `RCF_LEN_SHORT));
assign keep   = addr_ok & len_ok & (err_ok | ~FRAME_ERR);

// Transfer start: threshold reached or whole packet held
assign thr_hit   = fth_valid & (FIFO_PKT_BYTES >= fth_bytes);
assign start_now = ~started_reg & (FIFO_PKT_DONE | thr_hit);

// One start per packet; frame end rearms and wins over a start
always @*
begin
   started_next = started_reg;
   if (FRAME_END)
      started_next = 1'b0;
   else if (start_now)
      started_next = 1'b1;
end

// Interrupt events
always @*
begin
   ev = {`RCF_IRQ_W{1'b0}};
   ev[`RCF_IRQ_ACCEPT]  = FRAME_END & keep;
   ev[`RCF_IRQ_DROP]    = FRAME_END & ~keep;
   ev[`RCF_IRQ_EARLY]   = EARLY_EVENT & multi_sel;
   ev[`RCF_IRQ_BADCODE] = (fth < `RCF_CODE_MIN) | ~burst_valid;
end

// Level interrupt from unmasked sticky bits
assign IRQ = |(istat_reg & imask_reg);

// Config register next value; reserved bits stay zero
always @*
begin
   rxcfg_next = rxcfg_reg;
   if (wr_rxcfg)
      rxcfg_next = PWDATA & `RCF_RXCFG_WMASK;
end

// Config register
always @(posedge CLK or posedge RST)
begin
   if (RST)
      rxcfg_reg <= `RCF_RXCFG_RST;
   else
      rxcfg_reg <= rxcfg_next;
end

// Interrupt mask register
always @(posedge CLK or posedge RST)
begin
   if (RST)
      imask_reg <= {`RCF_IRQ_W{1'b0}};
   else if (wr_imask)
      imask_reg <= PWDATA[`RCF_IRQ_W-1:0];
end

// Per-bit status next value; set wins over write-one clear
generate
   for (gi = 0; gi < `RCF_IRQ_W; gi = gi + 1)
   begin : g_istat
      assign istat_next[gi] = ev[gi]
                            | (istat_reg[gi] & ~(wr_istat & PWDATA[gi]));
   end
endgenerate

// Interrupt status register
always @(posedge CLK or posedge RST)
begin
   if (RST)
      istat_reg <= {`RCF_IRQ_W{1'b0}};
   else
      istat_reg <= istat_next;
end

// Fitted EEPROM type placed at its read-only bit
assign eetype_word = {{(31-`RCF_BIT_EETYPE){1'b0}}, eetype_reg,
                      {`RCF_BIT_EETYPE{1'b0}}};

// Read data select
always @*
begin
   case (PADDR)
      `RCF_ADDR_RXCFG:
         rdata_next = rxcfg_reg | eetype_word;
      `RCF_ADDR_ISTAT:
         rdata_next = {{(32-`RCF_IRQ_W){1'b0}}, istat_reg};
      `RCF_ADDR_IMASK:
         rdata_next = {{(32-`RCF_IRQ_W){1'b0}}, imask_reg};
      default:
         rdata_next = `RCF_RDATA_ZERO;
   endcase
end

// Read data captured in setup cycle, held through access
always @(posedge CLK or posedge RST)
begin
   if (RST)
      rdata_reg <= `RCF_RDATA_ZERO;
   else if (acc_rd)
      rdata_reg <= rdata_next;
end

// EEPROM type sample; level pin, one clock late
always @(posedge CLK or posedge RST)
begin
   if (RST)
      eetype_reg <= 1'b0;
   else
      eetype_reg <= EEPROM_LARGE;
end

// Frame verdict pulses, one clock after frame end
always @(posedge CLK or posedge RST)
begin
   if (RST)
   begin
      FRAME_ACCEPT <= 1'b0;
      FRAME_DROP   <= 1'b0;
   end
   else
   begin
      FRAME_ACCEPT <= FRAME_END & keep;
      FRAME_DROP   <= FRAME_END & ~keep;
   end
end

// Host transfer start pulse and its once-per-packet guard
always @(posedge CLK or posedge RST)
begin
   if (RST)
   begin
      started_reg <= 1'b0;
      DMA_START   <= 1'b0;
   end
   else
   begin
      started_reg <= started_next;
      DMA_START   <= start_now;
   end
end

// Early interrupt pulse, only with multi early select
always @(posedge CLK or posedge RST)
begin
   if (RST)
      EARLY_IRQ <= 1'b0;
   else
      EARLY_IRQ <= ev[`RCF_IRQ_EARLY];
end

// Receive burst cap outputs
always @(posedge CLK or posedge RST)
begin
   if (RST)
   begin
      BURST_BYTES     <= {LEN_W{1'b0}};
      BURST_UNLIMITED <= 1'b0;
   end
   else
   begin
      BURST_BYTES     <= burst_bytes_next;
      BURST_UNLIMITED <= burst_free;
   end
end

// Hazard: reserved codes leave the cap at zero and flag status
// bit 3 for as long as they stand, so software sees the misuse.

endmodule

/* hdl/rcf_map.vh */
// Register map, field positions and constants of the receive filter
// Contract
// - Multi early select raises early irq per packet
// - Short check select: check frames over 8 bytes
// - Select clear (reset): check frames over 64 bytes
// - Error or runt accept forces 8-byte check
// - Start host transfer at threshold or whole packet
// - Threshold codes 010-110 decode 64..1024 bytes
// - Code 111 waits for whole packet
// - Burst limit 64..1024 bytes, 111 unlimited
// - EEPROM type bit reads fitted part type
// - Error accept keeps frames with errors
// - Error accept clear discards errored frames
// - Runt accept keeps frames 8 to 63 bytes
// - Broadcast accept bit admits broadcast frames
// - Multicast accept bit admits multicast frames
// - Physical match bit admits own-address frames
// - Promiscuous bit admits any destination
`ifndef RCF_MAP_VH
`define RCF_MAP_VH
`define RCF_ADDR_RXCFG   8'h44
`define RCF_ADDR_ISTAT   8'h48
`define RCF_ADDR_IMASK   8'h4C
`define RCF_RXCFG_WMASK  32'h0101E73F
`define RCF_BIT_MULTI    24
`define RCF_BIT_SHORT    16
`define RCF_FTH_HI       15
`define RCF_FTH_LO       13
`define RCF_BURST_HI     10
`define RCF_BURST_LO     8
`define RCF_BIT_EETYPE   6
`define RCF_BIT_ERR      5
`define RCF_BIT_RUNT     4
`define RCF_BIT_BCAST    3
`define RCF_BIT_MCAST    2
`define RCF_BIT_PHYS     1
`define RCF_BIT_PROM     0
`define RCF_CODE_NONE    3'h7
`define RCF_CODE_MIN     3'h2
`define RCF_LEN_SHORT    16'h0008
`define RCF_LEN_MIN      16'h0040
`define RCF_BYTES_BASE   16'h0040
`define RCF_BYTES_64     16'h0040
`define RCF_BYTES_128    16'h0080
`define RCF_BYTES_256    16'h0100
`define RCF_BYTES_512    16'h0200
`define RCF_BYTES_1024   16'h0400
`define RCF_CODE_64      3'h2
`define RCF_CODE_128     3'h3
`define RCF_CODE_256     3'h4
`define RCF_CODE_512     3'h5
`define RCF_CODE_1024    3'h6
`define RCF_RXCFG_RST    32'h00000000
`define RCF_RDATA_ZERO   32'h00000000
`define RCF_IRQ_W        4
`define RCF_IRQ_ACCEPT   0
`define RCF_IRQ_DROP     1
`define RCF_IRQ_EARLY    2
`define RCF_IRQ_BADCODE  3
`endif

/* sim/rcf_top_sva.sv */
// Port assertions for the receive filter
`timescale 1ns/100ps
module rcf_top_sva #(parameter LEN_W = 16)
(
   input logic             CLK,
   input logic             RST,
   input logic             FRAME_END,
   input logic [LEN_W-1:0] FRAME_LEN,
   input logic             FRAME_ACCEPT,
   input logic             FRAME_DROP,
   input logic             FCS_CHECK_EN,
   input logic             EARLY_EVENT,
   input logic             EARLY_IRQ,
   input logic             DMA_START
);
   // All checks on the controller clock
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);
   one_verdict_a: assert property (FRAME_END |=> FRAME_ACCEPT ^ FRAME_DROP)
      else $error("not exactly one verdict");
   quiet_idle_a: assert property
      (!FRAME_END |=> !(FRAME_ACCEPT | FRAME_DROP)) else $error("stray verdict");
   runt_floor_a: assert property
      (FRAME_END && FRAME_LEN < 8 |=> FRAME_DROP) else $error("tiny frame kept");
   fcs_short_a: assert property (FRAME_LEN <= 8 |-> !FCS_CHECK_EN)
      else $error("check on short frame");
   fcs_long_a: assert property (FRAME_LEN > 64 |-> FCS_CHECK_EN)
      else $error("no check on long frame");
   early_cause_a: assert property (EARLY_IRQ |-> $past(EARLY_EVENT))
      else $error("early irq without event");
   dma_once_a: assert property (DMA_START && !FRAME_END |=> !DMA_START)
      else $error("second transfer start");
   drop_cause_a: assert property (FRAME_DROP |-> $past(FRAME_END))
      else $error("drop without frame");
endmodule
bind rcf_top rcf_top_sva #(.LEN_W(LEN_W)) i_rcf_top_sva (
   .CLK(CLK), .RST(RST), .FRAME_END(FRAME_END), .FRAME_LEN(FRAME_LEN),
   .FRAME_ACCEPT(FRAME_ACCEPT), .FRAME_DROP(FRAME_DROP),
   .FCS_CHECK_EN(FCS_CHECK_EN), .EARLY_EVENT(EARLY_EVENT),
   .EARLY_IRQ(EARLY_IRQ), .DMA_START(DMA_START));

/* sim/rcf_host.sv */
// Host memory side: counts transfer starts
`timescale 1ns/100ps
module rcf_host
(
   input  logic CLK,
   input  logic DMA_START,
   output int   starts
);
   // One host transfer per start pulse
   initial starts = 0;
   always @(posedge CLK) if (DMA_START) starts <= starts + 1;
endmodule

/* sim/rcf_top_tb_top.sv */
// Bench: registers, filtering, transfer start and interrupt
`timescale 1ns/100ps
module rcf_top_tb_top;
   logic        CLK = 0, RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0;
   logic [7:0]  PADDR = '0;
   logic [31:0] PWDATA = '0, PRDATA, rv;
   logic        PREADY, PSLVERR, EEPROM_LARGE = 1, FRAME_END = 0, se;
   logic [15:0] FRAME_LEN = '0, FIFO_PKT_BYTES = '0, BURST_BYTES;
   logic        FRAME_BCAST = 0, FRAME_MCAST = 0, FRAME_PHYS = 0;
   logic        FRAME_ERR = 0, EARLY_EVENT = 0, FIFO_PKT_DONE = 0;
   logic        FCS_CHECK_EN, FRAME_ACCEPT, FRAME_DROP, DMA_START;
   logic        BURST_UNLIMITED, EARLY_IRQ, IRQ;
   int          errors = 0, samples_checked = 0, starts;
   // cfg, length, bcast/mcast/phys/err, expected accept
   logic [31:0] tab [9] = '{32'h08004081, 32'h00004080, 32'h04006441,
      32'h02004030, 32'h22004031, 32'h01004001, 32'h02003F20,
      32'h12000821, 32'h12000720};
   rcf_top i_rcf_top (
      .CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
      .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
      .PREADY(PREADY), .PSLVERR(PSLVERR), .EEPROM_LARGE(EEPROM_LARGE),
      .FRAME_END(FRAME_END), .FRAME_LEN(FRAME_LEN),
      .FRAME_BCAST(FRAME_BCAST), .FRAME_MCAST(FRAME_MCAST),
      .FRAME_PHYS(FRAME_PHYS), .FRAME_ERR(FRAME_ERR),
      .EARLY_EVENT(EARLY_EVENT), .FIFO_PKT_BYTES(FIFO_PKT_BYTES),
      .FIFO_PKT_DONE(FIFO_PKT_DONE), .FCS_CHECK_EN(FCS_CHECK_EN),
      .FRAME_ACCEPT(FRAME_ACCEPT), .FRAME_DROP(FRAME_DROP),
      .DMA_START(DMA_START), .BURST_BYTES(BURST_BYTES),
      .BURST_UNLIMITED(BURST_UNLIMITED), .EARLY_IRQ(EARLY_IRQ), .IRQ(IRQ));
   rcf_host i_rcf_host (.CLK(CLK), .DMA_START(DMA_START), .starts(starts));
   // 25 MHz clock
   initial forever #20 CLK = ~CLK;
   // One APB transfer, held until pready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge CLK);
      {PSEL, PENABLE, PWRITE, PADDR, PWDATA} <= {2'b10, w, a, d};
      @(posedge CLK);
      PENABLE <= 1;
      do @(posedge CLK); while (PREADY !== 1'b1);
      {rv, se} = {PRDATA, PSLVERR};
      {PSEL, PENABLE} <= 2'b00;
   endtask
   // Compare and count
   task automatic chk(input string n, input logic [31:0] e, s);
      samples_checked++;
      errors += int'(s !== e);
      if (s !== e) $display("wrong value %s exp %h seen %h", n, e, s);
   endtask
   task automatic complete_run;
      $display("checks %0d wrong %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // Hang guard
   initial
   begin
      #400000;
      errors++;
      complete_run;
   end
   initial
   begin
      repeat (6) @(posedge CLK);
      RST <= 0;
      apb(0, 8'h44, 0);
      chk("rxcfg reset", 32'h00000040, rv);
      apb(1, 8'h44, 32'hFFFFFFFF);
      apb(0, 8'h44, 0);
      chk("rxcfg mask", 32'h0101E77F, rv);
      apb(0, 8'h80, 0);
      chk("unmapped", 1, 32'(se));
      $display("registers done");
      apb(1, 8'h44, 32'h00004000);
      FIFO_PKT_BYTES <= 16'h0040;
      repeat (3) @(posedge CLK);
      chk("start at 64", 1, 32'(starts));
      {FRAME_END, FIFO_PKT_BYTES} <= {1'b1, 16'h0000};
      @(posedge CLK);
      FRAME_END <= 0;
      apb(1, 8'h44, 32'h0000E000);
      {FRAME_END, FIFO_PKT_BYTES} <= {1'b0, 16'h0400};
      repeat (3) @(posedge CLK);
      chk("held for whole", 1, 32'(starts));
      FIFO_PKT_DONE <= 1;
      repeat (3) @(posedge CLK);
      chk("start whole", 2, 32'(starts));
      FIFO_PKT_DONE <= 0;
      $display("transfer start done");
      foreach (tab[i])
      begin
         apb(1, 8'h44, {24'h0, tab[i][31:24]});
         {FRAME_END, FRAME_LEN} <= {1'b1, tab[i][23:8]};
         {FRAME_BCAST, FRAME_MCAST, FRAME_PHYS, FRAME_ERR} <= tab[i][7:4];
         @(posedge CLK);
         FRAME_END <= 0;
         @(negedge CLK);
         chk("accept", 32'(tab[i][0]), 32'(FRAME_ACCEPT));
         chk("drop", 32'(!tab[i][0]), 32'(FRAME_DROP));
         chk("check", 32'(tab[i][23:8] > (tab[i][29:28] != 0 ? 8 : 64)),
            32'(FCS_CHECK_EN));
      end
      $display("filter done");
      FRAME_LEN <= 16'h0009;
      for (int c = 2; c < 8; c++)
      begin
         apb(1, 8'h44, 32'h00010000 | (c << 8));
         repeat (2) @(negedge CLK);
         chk("burst", c == 7 ? 32'h10000 : 32'h40 << (c - 2),
            32'({BURST_UNLIMITED, BURST_BYTES}));
         chk("check len 9", 1, 32'(FCS_CHECK_EN));
      end
      $display("burst done");
      apb(1, 8'h4C, 32'h00000005);
      @(negedge CLK);
      chk("irq on", 1, 32'(IRQ));
      apb(1, 8'h48, 32'h00000001);
      @(negedge CLK);
      chk("irq cleared", 0, 32'(IRQ));
      apb(1, 8'h44, 32'h01000000);
      EARLY_EVENT <= 1;
      @(posedge CLK);
      EARLY_EVENT <= 0;
      @(negedge CLK);
      chk("early irq", 1, 32'(EARLY_IRQ));
      chk("early status irq", 1, 32'(IRQ));
      $display("interrupt done");
      complete_run;
   end
endmodule
